// *** verilog/asq_ctrl.sv ***
module asq_ctrl
    import asq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ASQ_ADDR_W-1:0] req_addr_i,
    input wire logic [ASQ_LANES-1:0] req_lanes_i,
    input wire logic [8*ASQ_LANES-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [8*ASQ_LANES-1:0] rsp_rdata_o,
    output logic [ASQ_ADDR_W-1:0] mem_addr_o,
    output logic [ASQ_LANES-1:0] byte_select_n_o,
    output logic [ASQ_LANES-1:0] byte_write_strobe_n_o,
    output logic output_enable_n_o,
    input wire logic [8*ASQ_LANES-1:0] dq_i,
    output logic [8*ASQ_LANES-1:0] dq_o,
    output logic [ASQ_LANES-1:0] dq_oe_n_o
);
    typedef struct packed
    {
        asq_state_t state;
        logic [ASQ_CNT_W-1:0] cnt;
        logic [ASQ_ADDR_W-1:0] addr;
        logic [ASQ_LANES-1:0] lanes;
        logic [8*ASQ_LANES-1:0] wdata;
        logic sel;
        logic wr;
        logic drive;
        logic oe_n;
        logic capture;
        logic ready;
        logic rsp;
    } asq_ctrl_st_t;
    asq_ctrl_st_t st_ff;
    asq_ctrl_st_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_sync_ff <= 2'b00;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.capture = 1'b0;
        nxt_st.rsp = 1'b0;
        case (st_ff.state)
            ASQ_IDLE:
            begin
                nxt_st.sel = 1'b0;
                nxt_st.wr = 1'b0;
                nxt_st.drive = 1'b0;
                nxt_st.oe_n = 1'b1;
                if (!st_ff.ready)
                begin
                    nxt_st.ready = 1'b1;
                end
                else if (req_valid_i && req_lanes_i != 4'h0)
                begin
                    nxt_st.ready = 1'b0;
                    nxt_st.addr = req_addr_i;
                    nxt_st.lanes = req_lanes_i;
                    nxt_st.wdata = req_wdata_i;
                    nxt_st.cnt = '0;
                    nxt_st.state = req_write_i ? ASQ_WR_TURN : ASQ_RD_SETUP;
                end
            end
            ASQ_RD_SETUP:
            begin
                nxt_st.sel = 1'b1;
                nxt_st.oe_n = 1'b0;
                nxt_st.state = ASQ_RD_WAIT;
            end
            ASQ_RD_WAIT:
            begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
                if (st_ff.cnt == 4'(ASQ_READ_CYC - 1))
                begin
                    nxt_st.capture = 1'b1;
                    nxt_st.state = ASQ_WR_HOLD;
                    nxt_st.cnt = '0;
                end
            end
            ASQ_WR_TURN:
            begin
                nxt_st.sel = 1'b1;
                nxt_st.wr = 1'b1;
                nxt_st.cnt = st_ff.cnt + 4'h1;
                // data drivers start only after the strobe has been low for the turn-off time
                if (st_ff.cnt == 4'(ASQ_TURNOFF_CYC))
                begin
                    nxt_st.drive = 1'b1;
                    nxt_st.cnt = '0;
                    nxt_st.state = ASQ_WR_PULSE;
                end
            end
            ASQ_WR_PULSE:
            begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
                if (st_ff.cnt == 4'(ASQ_WRITE_CYC - 1))
                begin
                    nxt_st.wr = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.state = ASQ_WR_HOLD;
                end
            end
            ASQ_WR_HOLD:
            begin
                nxt_st.wr = 1'b0;
                nxt_st.oe_n = 1'b1;
                nxt_st.cnt = st_ff.cnt + 4'h1;
                if (st_ff.cnt == 4'(ASQ_HOLD_CYC - 1))
                begin
                    nxt_st.sel = 1'b0;
                    nxt_st.drive = 1'b0;
                    nxt_st.rsp = ~st_ff.drive;
                    nxt_st.ready = 1'b1;
                    nxt_st.state = ASQ_IDLE;
                end
            end
            default:
            begin
                nxt_st.state = ASQ_IDLE;
                nxt_st.ready = 1'b1;
            end
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '{state: ASQ_IDLE, cnt: '0, addr: '0, lanes: '0, wdata: '0, sel: 1'b0, wr: 1'b0,
                       drive: 1'b0, oe_n: 1'b1, capture: 1'b0, ready: 1'b0, rsp: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < ASQ_LANES; gi++)
        begin : g_lane
            asq_lane u_lane
            (
                .core_clk_i(core_clk_i),
                .rst_n(rst_n),
                .sel_i(nxt_st.sel & nxt_st.lanes[gi]),
                .wr_i(nxt_st.wr),
                .drive_i(nxt_st.drive),
                .wdata_i(nxt_st.wdata[8*gi +: 8]),
                .capture_i(st_ff.capture & st_ff.lanes[gi]),
                .dq_in_i(dq_i[8*gi +: 8]),
                .byte_select_n_o(byte_select_n_o[gi]),
                .byte_write_strobe_n_o(byte_write_strobe_n_o[gi]),
                .dq_out_o(dq_o[8*gi +: 8]),
                .dq_oe_n_o(dq_oe_n_o[gi]),
                .rdata_o(rsp_rdata_o[8*gi +: 8])
            );
        end
    endgenerate
    logic rsp_dly_ff;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_dly_ff <= 1'b0;
        end
        else
        begin
            rsp_dly_ff <= st_ff.rsp;
        end
    end
    assign req_ready_o = st_ff.ready;
    assign rsp_valid_o = rsp_dly_ff;
    assign mem_addr_o = st_ff.addr;
    assign output_enable_n_o = st_ff.oe_n;
endmodule

// *** verilog/asq_pkg.sv ***
// Notes on behaviour
// - hold address at least read cycle time
// - enable-driven read holds address, enable, strobe
// - strobe-ended write measured from its start
// - select-ended write measured from its start
// - wait turn-off delay before driving data
package asq_pkg;
    localparam int ASQ_ADDR_W = 19;
    localparam int ASQ_LANES = 4;
    localparam int ASQ_CLK_PERIOD_NS = 50;
    localparam int ASQ_READ_CYCLE_NS = 25;
    localparam int ASQ_ACCESS_NS = 25;
    localparam int ASQ_WRITE_PULSE_NS = 25;
    localparam int ASQ_TURNOFF_NS = 10;
    localparam int ASQ_HOLD_NS = 3;
    // least times round up, at least one cycle; read access rounds up then adds one more cycle
    localparam int ASQ_READ_CYC = (ASQ_ACCESS_NS + ASQ_CLK_PERIOD_NS - 1) / ASQ_CLK_PERIOD_NS + 1;
    localparam int ASQ_WRITE_CYC = (ASQ_WRITE_PULSE_NS + ASQ_CLK_PERIOD_NS - 1) / ASQ_CLK_PERIOD_NS;
    localparam int ASQ_TURNOFF_CYC = (ASQ_TURNOFF_NS + ASQ_CLK_PERIOD_NS - 1) / ASQ_CLK_PERIOD_NS;
    localparam int ASQ_HOLD_CYC = (ASQ_HOLD_NS + ASQ_CLK_PERIOD_NS - 1) / ASQ_CLK_PERIOD_NS;
    localparam int ASQ_CNT_W = 4;
    typedef enum logic [2:0]
    {
        ASQ_IDLE = 3'b000,
        ASQ_RD_SETUP = 3'b001,
        ASQ_RD_WAIT = 3'b010,
        ASQ_WR_TURN = 3'b011,
        ASQ_WR_PULSE = 3'b100,
        ASQ_WR_HOLD = 3'b101
    } asq_state_t;
endpackage

// *** verilog/asq_lane.sv ***
module asq_lane
    import asq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n,
    input wire logic sel_i,
    input wire logic wr_i,
    input wire logic drive_i,
    input wire logic [7:0] wdata_i,
    input wire logic capture_i,
    input wire logic [7:0] dq_in_i,
    output logic byte_select_n_o,
    output logic byte_write_strobe_n_o,
    output logic [7:0] dq_out_o,
    output logic dq_oe_n_o,
    output logic [7:0] rdata_o
);
    typedef struct packed
    {
        logic sel_n;
        logic we_n;
        logic [7:0] dout;
        logic oe_n;
        logic [7:0] rdata;
    } asq_lane_st_t;
    asq_lane_st_t lane_ff;
    asq_lane_st_t nxt_lane;
    always_comb
    begin
        nxt_lane = lane_ff;
        nxt_lane.sel_n = ~sel_i;
        nxt_lane.we_n = ~(sel_i & wr_i);
        nxt_lane.oe_n = ~(sel_i & drive_i);
        nxt_lane.dout = wdata_i;
        if (capture_i)
        begin
            nxt_lane.rdata = dq_in_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lane_ff <= '{sel_n: 1'b1, we_n: 1'b1, dout: 8'h00, oe_n: 1'b1, rdata: 8'h00};
        end
        else
        begin
            lane_ff <= nxt_lane;
        end
    end
    assign byte_select_n_o = lane_ff.sel_n;
    assign byte_write_strobe_n_o = lane_ff.we_n;
    assign dq_out_o = lane_ff.dout;
    assign dq_oe_n_o = lane_ff.oe_n;
    assign rdata_o = lane_ff.rdata;
endmodule

// *** tb/asq_ctrl_chk.sv ***
module asq_ctrl_chk
    import asq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [ASQ_LANES-1:0] req_lanes_i,
    input wire logic [ASQ_ADDR_W-1:0] mem_addr_o,
    input wire logic [ASQ_LANES-1:0] byte_select_n_o,
    input wire logic [ASQ_LANES-1:0] byte_write_strobe_n_o,
    input wire logic output_enable_n_o,
    input wire logic [8*ASQ_LANES-1:0] dq_o,
    input wire logic [ASQ_LANES-1:0] dq_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    lane_select_a: assert property (
        req_valid_i && req_ready_o && |req_lanes_i |-> ##2 byte_select_n_o == ~$past(req_lanes_i, 2))
        else $error("lane selects differ from mask");
    read_quiet_a: assert property (!output_enable_n_o |-> &byte_write_strobe_n_o && &dq_oe_n_o)
        else $error("drive or strobe during read");
    turnoff_wait_a: assert property (|(~byte_write_strobe_n_o & $past(byte_write_strobe_n_o)) |-> &dq_oe_n_o)
        else $error("data driven at strobe fall");
    addr_hold_a: assert property (|~byte_select_n_o && $past(|~byte_select_n_o) |-> $stable(mem_addr_o))
        else $error("address moved while selected");
    read_addr_a: assert property (!output_enable_n_o && $past(!output_enable_n_o) |-> $stable(mem_addr_o))
        else $error("address moved during read");
    data_hold_a: assert property (|~dq_oe_n_o && $past(|~dq_oe_n_o) |-> $stable(dq_o))
        else $error("write data moved");
    strobe_end_a: assert property (
        |(byte_write_strobe_n_o & ~$past(byte_write_strobe_n_o)) |-> $stable(byte_select_n_o) ##1 &byte_select_n_o)
        else $error("write not ended by strobe");
    pulse_width_a: assert property (|(~byte_write_strobe_n_o & $past(byte_write_strobe_n_o)) |=> $stable(byte_write_strobe_n_o))
        else $error("write pulse too short");
endmodule

bind asq_ctrl asq_ctrl_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_lanes_i(req_lanes_i), .mem_addr_o(mem_addr_o), .byte_select_n_o(byte_select_n_o),
    .byte_write_strobe_n_o(byte_write_strobe_n_o), .output_enable_n_o(output_enable_n_o), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o));

// *** tb/asq_sram_model.sv ***
module asq_sram_model
    import asq_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [ASQ_ADDR_W-1:0] addr_i,
    input wire logic [ASQ_LANES-1:0] sel_n_i,
    input wire logic [ASQ_LANES-1:0] wr_n_i,
    input wire logic oe_n_i,
    input wire logic [8*ASQ_LANES-1:0] dq_i,
    output logic [8*ASQ_LANES-1:0] dq_o,
    output logic [ASQ_LANES-1:0] drv_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [int];
    logic [7:0] pat = 8'h5a;
    // floating pins show a pattern that moves every cycle
    always @(posedge core_clk_i)
        pat <= pat + 8'h3b;
    always @*
    begin
        for (int l = 0; l < ASQ_LANES; l++)
        begin
            drv_o[l] = !sel_n_i[l] && wr_n_i[l] && !oe_n_i;
            if (!sel_n_i[l] && !wr_n_i[l])
                mem[l * 524288 + int'(addr_i)] = dq_i[8*l+:8];
            dq_o[8*l+:8] = drv_o[l] ? mem[l * 524288 + int'(addr_i)] : pat;
        end
    end
endmodule

// *** tb/async_sram_quad_byte_module_tb.sv ***
module async_sram_quad_byte_module_tb
    import asq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [18:0] req_addr_i = 19'h0;
    logic [3:0] req_lanes_i = 4'h0;
    logic [31:0] req_wdata_i = 32'h0;
    logic req_ready_o, rsp_valid_o, output_enable_n_o;
    logic [31:0] rsp_rdata_o, dq_o, dq_i, mdq, d1, d2, m;
    logic [18:0] mem_addr_o, a;
    logic [3:0] byte_select_n_o, byte_write_strobe_n_o, dq_oe_n_o, mdrv, ln;
    logic [3:0] lt [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h7, 4'he, 4'h6};
    logic [31:0] exp_q [$];
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 32'h9439;
    asq_ctrl DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_lanes_i(req_lanes_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o),
        .byte_select_n_o(byte_select_n_o), .byte_write_strobe_n_o(byte_write_strobe_n_o),
        .output_enable_n_o(output_enable_n_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
    asq_sram_model u_mem (.core_clk_i(core_clk_i), .addr_i(mem_addr_o), .sel_n_i(byte_select_n_o),
        .wr_n_i(byte_write_strobe_n_o), .oe_n_i(output_enable_n_o), .dq_i(dq_i), .dq_o(mdq), .drv_o(mdrv));
    always_comb
        for (int l = 0; l < 4; l++)
            dq_i[8*l+:8] = dq_oe_n_o[l] ? mdq[8*l+:8] : dq_o[8*l+:8];
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one request, then a refused copy with other values while busy
    task automatic send(input logic w, input logic [18:0] ad, input logic [3:0] l, input logic [31:0] d);
        do
            @(posedge core_clk_i);
        while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= ad;
        req_lanes_i <= l;
        req_wdata_i <= d;
        if (!w)
            exp_q.push_back(d);
        @(posedge core_clk_i);
        req_addr_i <= ~ad;
        req_wdata_i <= ~d;
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
    endtask
    initial
        forever #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            complete_run();
        end
        if (|(mdrv & ~dq_oe_n_o))
            check("dq_contention", 32'h1, 32'h0);
        if (rsp_valid_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("rsp_valid_o", 32'h1, 32'h0);
            else
                check("rsp_rdata_o", rsp_rdata_o, exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            a = (i == 0) ? 19'h0 : (i == 1) ? 19'h7ffff : 19'($random(seed));
            d1 = $random(seed);
            d2 = $random(seed);
            ln = lt[i % 9];
            m = 32'h0;
            for (int l = 0; l < 4; l++)
                m[8*l+:8] = {8{ln[l]}};
            send(1'b1, a, 4'hf, d1);
            send(1'b1, a, ln, d2);
            send(1'b1, a, 4'h0, ~d2);
            send(1'b0, a, 4'hf, (d2 & m) | (d1 & ~m));
        end
        repeat (20) @(posedge core_clk_i);
        check("reads_left", exp_q.size(), 32'h0);
        complete_run();
    end
endmodule
